// ==== logic/fas_fault_regs.sv ====
// fault and cell alert status registers with power-on indicator
`timescale 1ns/100ps
`default_nettype none
module fas_fault_regs
  import fas_pkg::*;
#(
  parameter int OSC_PAIR_MIN = FAS_OSC_MIN_CYC,
  parameter int OSC_PAIR_MAX = FAS_OSC_MAX_CYC,
  parameter int SETTLE_CYC   = FAS_SETTLE_CYC
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire logic          clk_en,
  input  wire fas_pin_type   pins,
  input  wire fas_alert_type alerts,
  input  wire logic          diag_start,
  input  wire logic          diag_sample,
  input  wire logic [7:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [15:0]   reg_wdata,
  output logic [15:0]        reg_rdata,
  output logic               reg_rvalid,
  output logic               power_on_reset_indicator,
  output logic               fault_any
);

  // -------------------------------------------------------------
  // pin synchronisation and oscillator check
  // -------------------------------------------------------------
  fas_pin_type pin_s;
  logic        osc_stb;
  logic        osc_fail;

  fas_sync #(
    .WIDTH ($bits(fas_pin_type))
  ) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in (pins),
    .sync_out (pin_s)
  );

  fas_osc_check #(
    .PAIR_MIN (OSC_PAIR_MIN),
    .PAIR_MAX (OSC_PAIR_MAX)
  ) u_osc (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .lf_sync   (pin_s.lf_osc),
    .eval_stb  (osc_stb),
    .eval_fail (osc_fail)
  );

  // -------------------------------------------------------------
  // write decode
  // -------------------------------------------------------------
  logic wr_fault;
  logic wr_status;

  assign wr_fault  = clk_en & reg_wr & fas_hit(reg_addr, FAS_FAULT_OFS);
  assign wr_status = clk_en & reg_wr & fas_hit(reg_addr, FAS_STATUS_OFS);

  // -------------------------------------------------------------
  // power-on indicator
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      power_on_reset_indicator <= 1'b1;
    end else if (wr_status && !reg_wdata[FAS_POR_BIT]) begin
      power_on_reset_indicator <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // settling time monitor
  // -------------------------------------------------------------
  logic [FAS_CNT_W-1:0] settle_cnt;
  logic                 settle_short;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      settle_cnt <= '0;
    end else if (clk_en) begin
      if (diag_start) begin
        settle_cnt <= '0;
      end else if (settle_cnt < FAS_CNT_W'(SETTLE_CYC)) begin
        settle_cnt <= settle_cnt + 1'b1;
      end
    end
  end

  assign settle_short = diag_sample & ~diag_start &
                        (settle_cnt < FAS_CNT_W'(SETTLE_CYC - 1));

  // -------------------------------------------------------------
  // sticky fault flags
  // -------------------------------------------------------------
  logic [15:0] sticky;
  logic [15:0] sticky_set;
  logic [15:0] sticky_clr;
  logic [15:0] next_sticky;
  logic        gate;

  assign gate = ~power_on_reset_indicator;

  always_comb begin
    sticky_set                = '0;
    sticky_set[FAS_OSC1_BIT]  = osc_stb & osc_fail;
    sticky_set[FAS_OSC2_BIT]  = osc_stb & osc_fail;
    sticky_set[FAS_VDD3_BIT]  = gate & pin_s.vddl3_low;
    sticky_set[FAS_VDD2_BIT]  = gate & pin_s.vddl2_low;
    sticky_set[FAS_VDD1_BIT]  = gate & pin_s.vddl1_low;
    sticky_set[FAS_HVUV_BIT]  = gate & pin_s.hv_uv;
    sticky_set[FAS_GND1_BIT]  = gate & pin_s.gndl1_open;
    sticky_set[FAS_GND2_BIT]  = gate & pin_s.gndl2_open;
    sticky_set[FAS_GND3_BIT]  = gate & pin_s.gndl3_open;
    sticky_set[FAS_TEMP_BIT]  = pin_s.die_hot | settle_short;
  end

  // zeros clear, ones leave the flag alone
  assign sticky_clr  = wr_fault ? (~reg_wdata & FAS_STICKY_MASK) : '0;
  // set is or-ed after the clear so it wins
  assign next_sticky = ((sticky & ~sticky_clr) | sticky_set) &
                       FAS_STICKY_MASK;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sticky <= FAS_FAULT_RST;
    end else if (clk_en) begin
      sticky <= next_sticky;
    end
  end

  // -------------------------------------------------------------
  // single-ended receiver flags
  // -------------------------------------------------------------
  logic seu1;
  logic sel1;
  logic seu2;
  logic sel2;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      seu1 <= 1'b0;
      sel1 <= 1'b0;
    end else if (clk_en) begin
      if (gate && pin_s.upper_se) begin
        seu1 <= 1'b1;
      end
      if (gate && pin_s.lower_se) begin
        sel1 <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      seu2 <= 1'b0;
      sel2 <= 1'b0;
    end else if (clk_en) begin
      if (pin_s.upper_se) begin
        seu2 <= 1'b1;
      end
      if (pin_s.lower_se) begin
        sel2 <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // read words
  // -------------------------------------------------------------
  logic [15:0] fault_word;
  logic [15:0] cell_word;

  always_comb begin
    fault_word                = sticky;
    fault_word[FAS_ZERO_BIT]  = 1'b0;
    fault_word[FAS_SEU1_BIT]  = seu1;
    fault_word[FAS_SEL1_BIT]  = sel1;
    fault_word[FAS_SEU2_BIT]  = seu2;
    fault_word[FAS_SEL2_BIT]  = sel2;
    fault_word[FAS_BALSW_BIT] = |alerts.balsw;
  end

  always_comb begin
    cell_word        = '0;
    cell_word[13:12] = alerts.aux_input_over_alert |
                       alerts.aux_input_under_alert;
    cell_word[11:0]  = alerts.cell_ov | alerts.cell_uv;
  end

  assign fault_any = |fault_word;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (fas_hit(reg_addr, FAS_FAULT_OFS)) begin
          reg_rdata <= fault_word;
        end else if (fas_hit(reg_addr, FAS_CELL_OFS)) begin
          reg_rdata <= cell_word;
        end else if (fas_hit(reg_addr, FAS_STATUS_OFS)) begin
          reg_rdata <= {power_on_reset_indicator, 15'h0000};
        end else begin
          reg_rdata <= 16'h0000;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence osc_bad_s;
    clk_en && osc_stb && osc_fail;
  endsequence

  sequence write_zero_s(int b);
    wr_fault && !reg_wdata[b] && !sticky_set[b];
  endsequence

  osc_set_a: assert property (
    osc_bad_s |=> sticky[FAS_OSC1_BIT] && sticky[FAS_OSC2_BIT])
    else $error("oscillator alert not set");

  osc_spacing_a: assert property (
    clk_en && osc_stb |=> !osc_stb)
    else $error("oscillator verdict twice in a row");

  osc_copy_a: assert property (
    $rose(sticky[FAS_OSC2_BIT]) |-> $past(osc_stb && osc_fail))
    else $error("redundant oscillator alert without cause");

  zero_bits_a: assert property (
    reg_rvalid |-> !reg_rdata[13] || $past(reg_addr) == FAS_CELL_OFS)
    else $error("reserved fault bit reads one");

  upper_gate_a: assert property (
    $rose(seu1) |-> !$past(power_on_reset_indicator))
    else $error("upper flag set during power-on");

  lower_gate_a: assert property (
    $rose(sel1) |-> !$past(power_on_reset_indicator))
    else $error("lower flag set during power-on");

  early_copy_a: assert property (
    clk_en && pin_s.upper_se && pin_s.lower_se |=> seu2 && sel2)
    else $error("early single-ended copy missed");

  por_block_a: assert property (
    power_on_reset_indicator && clk_en && (sticky & 16'h01cf) == '0
    |=> (sticky & 16'h01cf) == '0)
    else $error("supply flag set during power-on");

  sticky_hold_a: assert property (
    clk_en && sticky[FAS_TEMP_BIT] && !wr_fault |=> sticky[FAS_TEMP_BIT])
    else $error("sticky flag lost without write");

  write_one_a: assert property (
    wr_fault && reg_wdata[FAS_GND1_BIT] && sticky[FAS_GND1_BIT]
    |=> sticky[FAS_GND1_BIT])
    else $error("write of one cleared flag");

  clear_a: assert property (
    write_zero_s(FAS_TEMP_BIT) |=> !sticky[FAS_TEMP_BIT])
    else $error("write of zero did not clear");

  cell_read_a: assert property (
    clk_en && reg_rd && reg_addr == FAS_CELL_OFS
    |=> reg_rvalid && reg_rdata[11:0] ==
        $past(alerts.cell_ov | alerts.cell_uv) && reg_rdata[15:14] == '0)
    else $error("cell summary read wrong");

  set_wins_a: assert property (
    wr_fault && !reg_wdata[FAS_TEMP_BIT] && sticky_set[FAS_TEMP_BIT]
    |=> sticky[FAS_TEMP_BIT])
    else $error("clear beat a coincident set");

  por_stay_a: assert property (
    !power_on_reset_indicator |=> !power_on_reset_indicator)
    else $error("power-on indicator set again");

  settle_set_a: assert property (
    clk_en && settle_short |=> sticky[FAS_TEMP_BIT])
    else $error("short settling not flagged");

  ground_latch_a: assert property (
    clk_en && gate && pin_s.gndl2_open |=> sticky[FAS_GND2_BIT])
    else $error("ground open flag not latched");

endmodule : fas_fault_regs
`default_nettype wire

// ==== logic/fas_pkg.sv ====
// constants and carrier types for the fault and alert status registers
//
// Summary of operation
// - oscillator outside plus or minus five percent sets fault bit 15
// - oscillator check result re-evaluated every two slow oscillator cycles
// - bit 14 repeats the oscillator alert: set the same way, cleared on its own by a zero write
// - fault bit 13 and cell summary bits 15..14 read zero, ignore writes
// - upper receiver single-ended flag sets only after power-on indicator clears
// - lower receiver single-ended flag sets only after power-on indicator clears
// - bits 10 and 9 copy single-ended flags, may set during power-on
// - supply low and ground open flags held off while power-on indicator set
// - each ground open flag latches for its own logic ground pin
// - sticky fault flags hold until software writes zero to them
// - writing one to a sticky flag leaves it unchanged
// - bit 5 is the OR of all balance switch alerts
// - bit 4 latches on hot die or settling shorter than 50 us
// - cell summary bits 13 and 12 are aux input over-or-under alerts
// - cell summary bits 11..0 are per-cell over-or-under alerts
// - power-on indicator set by reset, cleared by writing zero
package fas_pkg;

  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [7:0]  FAS_STATUS_OFS  = 8'h02;
  localparam logic [7:0]  FAS_FAULT_OFS   = 8'h03;
  localparam logic [7:0]  FAS_CELL_OFS    = 8'h04;
  localparam logic [15:0] FAS_FAULT_RST   = 16'h0000;
  localparam logic [15:0] FAS_STICKY_MASK = 16'hc1df;
  localparam int          FAS_POR_BIT     = 15;

  // fault register fields
  localparam int FAS_OSC1_BIT  = 15;
  localparam int FAS_OSC2_BIT  = 14;
  localparam int FAS_ZERO_BIT  = 13;
  localparam int FAS_SEU1_BIT  = 12;
  localparam int FAS_SEL1_BIT  = 11;
  localparam int FAS_SEU2_BIT  = 10;
  localparam int FAS_SEL2_BIT  = 9;
  localparam int FAS_VDD3_BIT  = 8;
  localparam int FAS_VDD2_BIT  = 7;
  localparam int FAS_GND2_BIT  = 6;
  localparam int FAS_BALSW_BIT = 5;
  localparam int FAS_TEMP_BIT  = 4;
  localparam int FAS_HVUV_BIT  = 3;
  localparam int FAS_GND3_BIT  = 2;
  localparam int FAS_VDD1_BIT  = 1;
  localparam int FAS_GND1_BIT  = 0;

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int FAS_CLK_MHZ      = 125;
  localparam int FAS_OSC_NOM_HZ   = 32000;
  localparam int FAS_OSC_TOL_PCT  = 5;
  localparam int FAS_OSC_PAIR_CYC = 2 * FAS_CLK_MHZ * 1000000 / FAS_OSC_NOM_HZ;
  localparam int FAS_OSC_MIN_CYC  =
    (FAS_OSC_PAIR_CYC * (100 - FAS_OSC_TOL_PCT) + 99) / 100;
  localparam int FAS_OSC_MAX_CYC  =
    FAS_OSC_PAIR_CYC * (100 + FAS_OSC_TOL_PCT) / 100;
  localparam int FAS_SETTLE_US    = 50;
  localparam int FAS_SETTLE_CYC   = FAS_SETTLE_US * FAS_CLK_MHZ;
  localparam int FAS_CNT_W        = 16;

  // -------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------
  typedef struct packed {
    logic lf_osc;
    logic upper_se;
    logic lower_se;
    logic vddl3_low;
    logic vddl2_low;
    logic vddl1_low;
    logic gndl3_open;
    logic gndl2_open;
    logic gndl1_open;
    logic hv_uv;
    logic die_hot;
  } fas_pin_type;

  typedef struct packed {
    logic [11:0] cell_ov;
    logic [11:0] cell_uv;
    logic [1:0]  aux_input_over_alert;
    logic [1:0]  aux_input_under_alert;
    logic [11:0] balsw;
  } fas_alert_type;

  function automatic logic fas_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    fas_hit = (addr == ofs);
  endfunction : fas_hit

endpackage : fas_pkg

// ==== logic/fas_sync.sv ====
// two-stage synchroniser bank for pin-level inputs
`timescale 1ns/100ps
`default_nettype none
module fas_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : fas_sync
`default_nettype wire

// ==== logic/fas_osc_check.sv ====
// slow oscillator frequency check over two of its cycles
`timescale 1ns/100ps
`default_nettype none
module fas_osc_check
  import fas_pkg::*;
#(
  parameter int PAIR_MIN = FAS_OSC_MIN_CYC,
  parameter int PAIR_MAX = FAS_OSC_MAX_CYC
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic lf_sync,
  output logic      eval_stb,
  output logic      eval_fail
);

  logic                 lf_prev;
  logic                 armed;
  logic                 half;
  logic [FAS_CNT_W-1:0] cnt;
  logic                 fall;
  logic                 stall;

  // falling edges only: the synchroniser resets low, so a pin high at
  // reset release gives a false rise but never a false fall
  assign fall  = ~lf_sync & lf_prev;
  // a stopped oscillator must still be reported
  assign stall = (cnt >= FAS_CNT_W'(PAIR_MAX));

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      lf_prev <= 1'b0;
    end else if (clk_en) begin
      lf_prev <= lf_sync;
    end
  end

  // verdict once per two slow cycles; cnt holds the cycles since the
  // window opened, so it equals the pair length at the closing edge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      armed     <= 1'b0;
      half      <= 1'b0;
      cnt       <= '0;
      eval_stb  <= 1'b0;
      eval_fail <= 1'b0;
    end else if (clk_en) begin
      eval_stb <= 1'b0;
      if (stall) begin
        cnt       <= '0;
        armed     <= 1'b0;
        half      <= 1'b0;
        eval_stb  <= 1'b1;
        eval_fail <= 1'b1;
      end else if (fall && !armed) begin
        // the window opens on an edge, never at reset or after a stall
        cnt   <= FAS_CNT_W'(1);
        armed <= 1'b1;
        half  <= 1'b0;
      end else if (fall && half) begin
        cnt       <= FAS_CNT_W'(1);
        half      <= 1'b0;
        eval_stb  <= 1'b1;
        eval_fail <= (cnt < FAS_CNT_W'(PAIR_MIN));
      end else begin
        cnt <= cnt + 1'b1;
        if (fall) begin
          half <= 1'b1;
        end
      end
    end
  end

endmodule : fas_osc_check
`default_nettype wire

// ==== testbench/fas_fault_regs_bench.sv ====
// self-checking bench for the fault and alert status registers
`timescale 1ns/100ps
`default_nettype none
module fas_fault_regs_bench
  import fas_pkg::*;
();

  // ---------------------------------------------------------------
  // stimulus and model state
  // ---------------------------------------------------------------
  localparam int SETTLE = 10;
  logic          clk_sys = 1'b0;
  logic          resetn;
  logic          clk_en;
  fas_pin_type   pins;
  fas_alert_type alerts;
  logic          diag_start;
  logic          diag_sample;
  logic [7:0]    reg_addr;
  logic          reg_wr;
  logic          reg_rd;
  logic [15:0]   reg_wdata;
  logic [15:0]   reg_rdata;
  logic          reg_rvalid;
  logic          power_on_reset_indicator;
  logic          fault_any;
  logic [15:0]   mf;
  logic [63:0]   r;
  int            lf_half;
  int            err_total;
  int            n_checks;
  int            fb[8] = '{4, 3, 0, 6, 2, 1, 7, 8};

  fas_fault_regs #(
    .OSC_PAIR_MIN (20),
    .OSC_PAIR_MAX (40),
    .SETTLE_CYC   (SETTLE)
  ) u_dut (
    .clk_sys                  (clk_sys),
    .resetn                   (resetn),
    .clk_en                   (clk_en),
    .pins                     (pins),
    .alerts                   (alerts),
    .diag_start               (diag_start),
    .diag_sample              (diag_sample),
    .reg_addr                 (reg_addr),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_wdata                (reg_wdata),
    .reg_rdata                (reg_rdata),
    .reg_rvalid               (reg_rvalid),
    .power_on_reset_indicator (power_on_reset_indicator),
    .fault_any                (fault_any)
  );

  always #4 clk_sys = ~clk_sys;

  // slow oscillator; a half period of zero stops it
  always begin
    if (lf_half == 0) begin
      @(posedge clk_sys);
    end else begin
      repeat (lf_half) @(posedge clk_sys);
      #1;
      pins.lf_osc = ~pins.lf_osc;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  function automatic logic [15:0] fx();
    fx = mf | {10'h000, |alerts.balsw, 5'h00};
  endfunction : fx

  function automatic logic [15:0] cx();
    cx = {2'h0, alerts.aux_input_over_alert | alerts.aux_input_under_alert,
          alerts.cell_ov | alerts.cell_uv};
  endfunction : cx

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    int k;
    reg_addr = a;
    reg_rd   = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    for (k = 0; k < 4; k++) begin
      if (reg_rvalid === 1'b1) break;
      cyc(1);
    end
    if (k == 4) begin
      err_total++;
      $display("Error at %0t: no answer at %h expected %h", $time, a, exp);
      end_of_test();
    end else begin
      chk(reg_rdata, exp);
    end
    cyc(1);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic diag(input int gap);
    diag_start = 1'b1;
    cyc(1);
    diag_start = 1'b0;
    cyc(gap);
    diag_sample = 1'b1;
    cyc(1);
    diag_sample = 1'b0;
    cyc(2);
  endtask : diag

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    pins = '0;
    alerts = '0;
    diag_start = 1'b0;
    diag_sample = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
    lf_half = 7;
    err_total = 0;
    n_checks = 0;
    mf = 16'h0000;
    void'($urandom(66059));
    cyc(6);
    resetn = 1'b1;
    rd(8'h03, fx());
    rd(8'h04, 16'h0000);
    rd(8'h02, 16'h8000);
    $display("test reset_values done");

    pins[9:1] = 9'h1ff;
    cyc(5);
    mf = 16'h0600;
    rd(8'h03, fx());
    wr(8'h02, 16'h8000);
    rd(8'h02, 16'h8000);
    wr(8'h02, 16'h0000);
    rd(8'h02, 16'h0000);
    chk({15'h0000, power_on_reset_indicator}, 16'h0000);
    cyc(5);
    mf = 16'h1fcf;
    rd(8'h03, fx());
    pins[9:1] = 9'h000;
    cyc(5);
    rd(8'h03, fx());
    wr(8'h03, 16'hffff);
    rd(8'h03, fx());
    wr(8'h03, 16'hfffe);
    mf = 16'h1fce;
    rd(8'h03, fx());
    wr(8'h03, 16'h0000);
    mf = 16'h1e00;
    rd(8'h03, fx());
    $display("test power_on_gating done");

    for (int i = 0; i < 8; i++) begin
      pins[i] = 1'b1;
      cyc(5);
      wr(8'h03, 16'h0000);
      mf = 16'h1e00 | (16'h0001 << fb[i]);
      rd(8'h03, fx());
      pins[i] = 1'b0;
      cyc(5);
      rd(8'h03, fx());
      wr(8'h03, 16'h0000);
      mf = 16'h1e00;
      rd(8'h03, fx());
    end
    $display("test pin_flags done");

    diag(3);
    mf = 16'h1e10;
    rd(8'h03, fx());
    clk_en = 1'b0;
    wr(8'h03, 16'h0000);
    clk_en = 1'b1;
    rd(8'h03, fx());
    wr(8'h03, 16'h0000);
    mf = 16'h1e00;
    diag(SETTLE + 5);
    rd(8'h03, fx());
    $display("test settle done");

    lf_half = 3;
    cyc(120);
    mf = 16'hde00;
    rd(8'h03, fx());
    lf_half = 7;
    cyc(100);
    wr(8'h03, 16'h7fff);
    mf = 16'h5e00;
    rd(8'h03, fx());
    wr(8'h03, 16'h0000);
    mf = 16'h1e00;
    rd(8'h03, fx());
    lf_half = 0;
    cyc(120);
    mf = 16'hde00;
    rd(8'h03, fx());
    lf_half = 7;
    cyc(100);
    wr(8'h03, 16'h0000);
    mf = 16'h1e00;
    rd(8'h03, fx());
    $display("test oscillator done");

    for (int i = 0; i < 9; i++) begin
      r = {$urandom(), $urandom()};
      if (i == 0) r = '0;
      alerts = fas_alert_type'(r[39:0]);
      cyc(1);
      rd(8'h04, cx());
      rd(8'h03, fx());
      chk({15'h0000, fault_any}, {15'h0000, |fx()});
      wr(8'h04, 16'hffff);
      rd(8'h04, cx());
    end
    rd(8'h07, 16'h0000);
    $display("test cell_summary done");

    alerts = '0;
    resetn = 1'b0;
    cyc(3);
    resetn = 1'b1;
    mf = 16'h0000;
    rd(8'h03, fx());
    rd(8'h02, 16'h8000);
    chk({15'h0000, fault_any}, {15'h0000, |fx()});
    $display("test second_reset done");
    end_of_test();
  end

endmodule : fas_fault_regs_bench
`default_nettype wire
